/* File: rtl/bcb_exec.sv */
/*
  carry-bit manipulation and program-flow execution stage with an AXI4-Lite
  status/control slave. assumes the decoder supplies bit number, byte operand,
  target and next-instruction address, and that ccr_in is the live flag byte.
*/
// Operation
// - carry becomes carry xor the selected operand bit.
// - carry becomes carry xor the complement of the selected operand bit.
// - carry takes the selected operand bit and the operand is left alone.
// - carry takes the complement of the selected operand bit.
// - the selected operand bit takes the carry, other bits kept.
// - the selected operand bit takes the inverted carry, other bits kept.
// - all six bit forms, inverted or not, take the bit position from the 3-bit bit number.
// - a true condition loads the target, else execution goes on sequentially.
// - single-flag conditions test C, Z, V or N for clear or set.
// - compound conditions cover always, never, C or Z, N xor V and Z or (N xor V).
// - both call forms save the next address unless the stack is full, and then go to the target.
`timescale 1ns/1ps
`default_nettype none
`include "bcb_defs.svh"

module bcb_exec (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire bcb_pkg::bcb_req_t req_in,
  input wire logic [7:0] ccr_in,
  output logic ready_out,
  output logic [7:0] ccr_out,
  output logic ccr_we_out,
  output logic [7:0] res_out,
  output logic res_we_out,
  output logic [`BCB_PC_W-1:0] pc_out,
  output logic pc_load_out,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  bcb_pkg::bcb_state_t s;
  bcb_pkg::bcb_state_t next_s;
  logic mem_we;
  logic [`BCB_RA_W-1:0] mem_waddr;
  logic [`BCB_RA_W-1:0] mem_raddr;
  logic [`BCB_PC_W-1:0] mem_rdata;

  function automatic logic cond_true(input logic [3:0] cc, input logic [7:0] f);
    logic c;
    logic v;
    logic z;
    logic n;
    c = f[`BCB_C_POS];
    v = f[`BCB_V_POS];
    z = f[`BCB_Z_POS];
    n = f[`BCB_N_POS];
    case (cc)
      `BCB_UNCONDITIONAL_TAKEN: cond_true = 1'b1;
      `BCB_NEVER_TAKEN: cond_true = 1'b0;
      `BCB_UNSIGNED_HIGHER_COND: cond_true = !(c | z);
      `BCB_UNSIGNED_LOWER_OR_SAME_COND: cond_true = c | z;
      `BCB_CARRY_CLEAR_COND: cond_true = !c;
      `BCB_CARRY_SET_COND: cond_true = c;
      `BCB_NOT_EQUAL_COND: cond_true = !z;
      `BCB_EQUAL_COND: cond_true = z;
      `BCB_OVERFLOW_CLEAR_COND: cond_true = !v;
      `BCB_OVERFLOW_SET_COND: cond_true = v;
      `BCB_PLUS_COND: cond_true = !n;
      `BCB_MINUS_COND: cond_true = n;
      `BCB_SIGNED_GE_COND: cond_true = !(n ^ v);
      `BCB_SIGNED_LESS_COND: cond_true = n ^ v;
      `BCB_SIGNED_GREATER_COND: cond_true = !(z | (n ^ v));
      `BCB_SIGNED_LE_COND: cond_true = z | (n ^ v);
      default: cond_true = 1'b0;
    endcase
  endfunction : cond_true

  // replaces one bit of a byte, the rest passes through
  function automatic logic [7:0] put_bit(input logic [7:0] d, input logic [2:0] pos, input logic b);
    logic [7:0] r;
    r = d;
    r[pos] = b;
    put_bit = r;
  endfunction : put_bit

  function automatic logic [31:0] read_mux(input logic [`BCB_ADDR_W-1:0] a, input bcb_pkg::bcb_state_t st);
    logic [31:0] r;
    r = '0;
    case (a)
      `BCB_STATUS_OFS: begin
        r[7:0] = st.ccr;
        r[`BCB_ST_DEPTH_LSB +: `BCB_SP_W] = st.sp;
        r[`BCB_ST_OVF_POS] = st.ovf;
        r[`BCB_ST_UNF_POS] = st.unf;
      end
      `BCB_PC_OFS: r[`BCB_PC_W-1:0] = st.pc;
      default: r = '0;
    endcase
    read_mux = r;
  endfunction : read_mux

  function automatic logic mapped(input logic [`BCB_ADDR_W-1:0] a);
    mapped = (a == `BCB_STATUS_OFS) || (a == `BCB_PC_OFS) || (a == `BCB_CTRL_OFS);
  endfunction : mapped

  assign ready_out = (s.fsm == bcb_pkg::bcb_idle);
  assign ccr_out = s.ccr;
  assign ccr_we_out = s.ccr_we;
  assign res_out = s.res;
  assign res_we_out = s.res_we;
  assign pc_out = s.pc;
  assign pc_load_out = s.pc_load;
  assign s_axi_awready = !s.awv && !s.bvalid;
  assign s_axi_wready = !s.wv && !s.bvalid;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;

  always_comb begin
    logic c;
    logic b;
    c = ccr_in[`BCB_C_POS];
    b = req_in.operand[req_in.bitno];
    next_s = s;
    next_s.ccr_we = 1'b0;
    next_s.res_we = 1'b0;
    next_s.pc_load = 1'b0;
    mem_we = 1'b0;
    mem_waddr = s.sp[`BCB_RA_W-1:0];
    mem_raddr = 3'(s.sp - `BCB_SP_ONE);

    // bus side first, so a hardware set below wins over a software clear
    if (s_axi_awvalid && s_axi_awready) begin
      next_s.awv = 1'b1;
      next_s.awaddr = s_axi_awaddr[`BCB_ADDR_W-1:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.wv = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    if (s.awv && s.wv) begin
      next_s.awv = 1'b0;
      next_s.wv = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = mapped(s.awaddr) ? `BCB_RESP_OKAY : `BCB_RESP_SLVERR;
      if (s.awaddr == `BCB_CTRL_OFS && s.wstrb[0] && s.wdata[`BCB_CTRL_CLR_POS]) begin
        next_s.sp = '0;
        next_s.ovf = 1'b0;
        next_s.unf = 1'b0;
      end
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s.rvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = read_mux(s_axi_araddr[`BCB_ADDR_W-1:0], s);
      next_s.rresp = mapped(s_axi_araddr[`BCB_ADDR_W-1:0]) ? `BCB_RESP_OKAY : `BCB_RESP_SLVERR;
    end

    case (s.fsm)
      bcb_pkg::bcb_idle: begin
        if (req_in.valid) begin
          next_s.ccr = ccr_in;
          next_s.res = req_in.operand;
          case (req_in.op)
            bcb_pkg::carry_xor_with_bit: begin
              next_s.ccr[`BCB_C_POS] = c ^ b;
              next_s.ccr_we = 1'b1;
            end
            bcb_pkg::carry_xor_inverted_bit: begin
              next_s.ccr[`BCB_C_POS] = c ^ !b;
              next_s.ccr_we = 1'b1;
            end
            bcb_pkg::load_bit_to_carry: begin
              next_s.ccr[`BCB_C_POS] = b;
              next_s.ccr_we = 1'b1;
            end
            bcb_pkg::load_inverted_bit_to_carry: begin
              next_s.ccr[`BCB_C_POS] = !b;
              next_s.ccr_we = 1'b1;
            end
            bcb_pkg::store_carry_to_bit: begin
              next_s.res = put_bit(req_in.operand, req_in.bitno, c);
              next_s.res_we = 1'b1;
            end
            bcb_pkg::store_inverted_carry_to_bit: begin
              next_s.res = put_bit(req_in.operand, req_in.bitno, !c);
              next_s.res_we = 1'b1;
            end
            bcb_pkg::cond_branch: begin
              next_s.pc = cond_true(req_in.cond, ccr_in) ? req_in.target : req_in.next_pc;
              next_s.pc_load = 1'b1;
            end
            bcb_pkg::jump_absolute: begin
              next_s.pc = req_in.target;
              next_s.pc_load = 1'b1;
            end
            bcb_pkg::call_relative, bcb_pkg::call_absolute: begin
              // a full stack still branches but drops this call's return address and keeps the older ones
              if (s.sp == `BCB_STACK_DEPTH) begin
                next_s.ovf = 1'b1;
              end else begin
                mem_we = 1'b1;
                next_s.sp = s.sp + `BCB_SP_ONE;
              end
              next_s.pc = req_in.target;
              next_s.pc_load = 1'b1;
            end
            bcb_pkg::sub_return: begin
              if (s.sp == '0) begin
                next_s.unf = 1'b1;
                next_s.pc = req_in.next_pc;
                next_s.pc_load = 1'b1;
              end else begin
                next_s.sp = s.sp - `BCB_SP_ONE;
                next_s.fsm = bcb_pkg::bcb_ret_wait;
              end
            end
            default: begin
              next_s.ccr = s.ccr;
            end
          endcase
        end
      end
      bcb_pkg::bcb_ret_wait: begin
        next_s.pc = mem_rdata;
        next_s.pc_load = 1'b1;
        next_s.fsm = bcb_pkg::bcb_idle;
      end
      default: next_s.fsm = bcb_pkg::bcb_idle;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  bcb_ret_mem #(
    .DEPTH(`BCB_STACK_DEPTH),
    .WIDTH(`BCB_PC_W),
    .AW(`BCB_RA_W)
  ) u_ret_mem (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .we_in(mem_we),
    .waddr_in(mem_waddr),
    .wdata_in(req_in.next_pc),
    .raddr_in(mem_raddr),
    .rdata_out(mem_rdata)
  );

  // helper copies of the previous cycle's request and flags, read only by the checks
  logic h_c;
  logic h_b;
  logic [7:0] h_f;
  logic [7:0] h_op;
  logic [2:0] h_pos;
  always_ff @(posedge clk_in) begin
    h_c <= ccr_in[`BCB_C_POS];
    h_b <= req_in.operand[req_in.bitno];
    h_f <= ccr_in;
    h_op <= req_in.operand;
    h_pos <= req_in.bitno;
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  sequence take(bcb_pkg::bcb_op_t o);
    ready_out && req_in.valid && req_in.op == o;
  endsequence

  sequence ret_deep;
    take(bcb_pkg::sub_return) ##0 (s.sp != '0);
  endsequence

  carry_xor_a: assert property (take(bcb_pkg::carry_xor_with_bit) |=> ccr_we_out && ccr_out[`BCB_C_POS] == (h_c ^ h_b))
    else $error("carry xor with bit wrong");
  carry_xor_inv_a: assert property (take(bcb_pkg::carry_xor_inverted_bit) |=> ccr_out[`BCB_C_POS] == (h_c ^ !h_b))
    else $error("carry xor with inverted bit wrong");
  bit_load_a: assert property (take(bcb_pkg::load_bit_to_carry) |=> ccr_out[`BCB_C_POS] == h_b && !res_we_out)
    else $error("bit load wrong");
  bit_load_inv_a: assert property (take(bcb_pkg::load_inverted_bit_to_carry) |=> ccr_out[`BCB_C_POS] == !h_b)
    else $error("inverted bit load wrong");
  bit_store_a: assert property (take(bcb_pkg::store_carry_to_bit) |=> res_we_out && res_out[h_pos] == h_c
    && (res_out ^ h_op) == ((h_c ^ h_b) ? (8'h01 << h_pos) : 8'h00))
    else $error("bit store wrong");
  bit_store_inv_a: assert property (take(bcb_pkg::store_inverted_carry_to_bit) |=> res_we_out
    && res_out[h_pos] == !h_c && !ccr_we_out)
    else $error("inverted bit store wrong");
  flags_kept_a: assert property (ccr_we_out |-> (ccr_out | 8'h01) == (h_f | 8'h01))
    else $error("flag other than carry changed");
  branch_target_a: assert property (take(bcb_pkg::cond_branch) ##0 cond_true(req_in.cond, ccr_in)
    |=> pc_load_out && pc_out == $past(req_in.target))
    else $error("taken branch missed target");
  branch_fall_a: assert property (take(bcb_pkg::cond_branch) ##0 !cond_true(req_in.cond, ccr_in)
    |=> pc_load_out && pc_out == $past(req_in.next_pc))
    else $error("untaken branch did not fall through");
  jump_load_a: assert property (take(bcb_pkg::jump_absolute) |=> pc_load_out && pc_out == $past(req_in.target))
    else $error("jump target not loaded");
  call_push_a: assert property (take(bcb_pkg::call_absolute) ##0 (s.sp != `BCB_STACK_DEPTH)
    |=> pc_load_out && s.sp == $past(s.sp) + `BCB_SP_ONE)
    else $error("call did not save return address");
  ret_timing_a: assert property (ret_deep |=> !pc_load_out && !ready_out ##1 pc_load_out && ready_out)
    else $error("return reload timing wrong");

endmodule : bcb_exec

`default_nettype wire

/* File: rtl/bcb_ret_mem.sv */
/*
  return-address memory: one write port, one read port with registered data.
  assumes a single clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module bcb_ret_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 24,
  parameter int AW = 3
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [WIDTH-1:0] wdata_in,
  input wire logic [AW-1:0] raddr_in,
  output logic [WIDTH-1:0] rdata_out
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
    if (!rstn_in) begin
      rdata_out <= '0;
    end else begin
      rdata_out <= mem[raddr_in];
    end
  end

endmodule : bcb_ret_mem

`default_nettype wire

/* File: shared/bcb_defs.svh */
/*
  constants of the carry-bit and branch-condition execution block:
  flag positions, widths, condition encodings, register offsets and fields.
  assumes inclusion by bare name from the package and the design files.
*/
`ifndef BCB_DEFS_SVH
`define BCB_DEFS_SVH

// flag positions inside the condition-code byte
`define BCB_C_POS 0
`define BCB_V_POS 1
`define BCB_Z_POS 2
`define BCB_N_POS 3

`define BCB_PC_W 24
`define BCB_SP_W 4
`define BCB_RA_W 3
`define BCB_STACK_DEPTH 4'h8
`define BCB_SP_ONE 4'h1

// condition field encodings
`define BCB_UNCONDITIONAL_TAKEN 4'h0
`define BCB_NEVER_TAKEN 4'h1
`define BCB_UNSIGNED_HIGHER_COND 4'h2
`define BCB_UNSIGNED_LOWER_OR_SAME_COND 4'h3
`define BCB_CARRY_CLEAR_COND 4'h4
`define BCB_CARRY_SET_COND 4'h5
`define BCB_NOT_EQUAL_COND 4'h6
`define BCB_EQUAL_COND 4'h7
`define BCB_OVERFLOW_CLEAR_COND 4'h8
`define BCB_OVERFLOW_SET_COND 4'h9
`define BCB_PLUS_COND 4'ha
`define BCB_MINUS_COND 4'hb
`define BCB_SIGNED_GE_COND 4'hc
`define BCB_SIGNED_LESS_COND 4'hd
`define BCB_SIGNED_GREATER_COND 4'he
`define BCB_SIGNED_LE_COND 4'hf

// register bus
`define BCB_ADDR_W 4
`define BCB_STATUS_OFS 4'h0
`define BCB_PC_OFS 4'h4
`define BCB_CTRL_OFS 4'h8
`define BCB_CTRL_CLR_POS 0
`define BCB_ST_DEPTH_LSB 8
`define BCB_ST_OVF_POS 16
`define BCB_ST_UNF_POS 17
`define BCB_RESP_OKAY 2'h0
`define BCB_RESP_SLVERR 2'h2

`endif

/* File: shared/bcb_pkg.sv */
/*
  types of the carry-bit and branch-condition execution block.
  assumes bcb_defs.svh is on the include path.
*/
`include "bcb_defs.svh"

package bcb_pkg;

  typedef enum logic [3:0] {
    carry_xor_with_bit,
    carry_xor_inverted_bit,
    load_bit_to_carry,
    load_inverted_bit_to_carry,
    store_carry_to_bit,
    store_inverted_carry_to_bit,
    cond_branch,
    jump_absolute,
    call_relative,
    call_absolute,
    sub_return
  } bcb_op_t;

  typedef enum logic {
    bcb_idle,
    bcb_ret_wait
  } bcb_fsm_t;

  // one decoded instruction from the decoder
  typedef struct packed {
    logic valid;
    bcb_op_t op;
    logic [3:0] cond;
    logic [2:0] bitno;
    logic [7:0] operand;
    logic [`BCB_PC_W-1:0] target;
    logic [`BCB_PC_W-1:0] next_pc;
  } bcb_req_t;

  typedef struct packed {
    logic [7:0] ccr;
    logic ccr_we;
    logic [7:0] res;
    logic res_we;
    logic [`BCB_PC_W-1:0] pc;
    logic pc_load;
    logic [`BCB_SP_W-1:0] sp;
    bcb_fsm_t fsm;
    logic ovf;
    logic unf;
    logic awv;
    logic [`BCB_ADDR_W-1:0] awaddr;
    logic wv;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } bcb_state_t;

endpackage : bcb_pkg

/* File: test/bcb_exec_bench.sv */
/*
  self-checking bench of the carry-bit and branch-condition stage: bit ops,
  every branch condition, jump, call/return and the register bus.
  assumes bcb_pkg and the stage are compiled first; the stage's own assertions sit in its body.
*/
`timescale 1ns/1ps
`default_nettype none

module bcb_exec_bench;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  bcb_pkg::bcb_req_t req = '0;
  logic [7:0] ccr = 8'h00;
  logic ready, ccr_we, res_we, pc_load;
  logic [7:0] ccr_o, res_o;
  logic [23:0] pc_o;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic g_cwe, g_rwe, g_pl;
  logic [7:0] g_ccr, g_res;
  logic [23:0] g_pc;
  int g_lat;
  int bad_count = 0;
  int cmp_count = 0;

  always #5 clk_in = ~clk_in;

  bcb_exec dut_u (
    .clk_in(clk_in), .rstn_in(rstn_in), .req_in(req), .ccr_in(ccr), .ready_out(ready),
    .ccr_out(ccr_o), .ccr_we_out(ccr_we), .res_out(res_o), .res_we_out(res_we),
    .pc_out(pc_o), .pc_load_out(pc_load),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic timeout();
    $display("mismatch at %0t got %h expected %h", $time, 32'h0, 32'h1);
    bad_count++;
    test_done();
  endtask : timeout

  // outputs are read right after the edge, so they are the values the edge sampled
  task automatic exec(input bcb_pkg::bcb_op_t op, input logic [3:0] cd, input logic [2:0] bn,
                      input logic [7:0] opd, input logic [23:0] tgt, input logic [23:0] nxt,
                      input logic [7:0] cc);
    req <= '{1'b1, op, cd, bn, opd, tgt, nxt};
    ccr <= cc;
    @(posedge clk_in);
    req.valid <= 1'b0;
    g_lat = 0;
    for (int n = 1; n <= 4 && g_lat == 0; n++) begin
      @(posedge clk_in);
      if ((ccr_we | res_we | pc_load) === 1'b1) g_lat = n;
    end
    if (g_lat == 0) timeout();
    g_cwe = ccr_we;
    g_rwe = res_we;
    g_pl = pc_load;
    g_ccr = ccr_o;
    g_res = res_o;
    g_pc = pc_o;
  endtask : exec

  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk_in);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    if (n == 16) timeout();
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // one idle edge so a following transfer never re-raises bready in this step
    @(posedge clk_in);
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk_in);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    if (n == 16) timeout();
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk_in);
  endtask : axi_rd

  function automatic logic taken(input logic [3:0] cd, input logic [3:0] f);
    logic c, v, z, n;
    {n, z, v, c} = f;
    case (cd)
      4'h0: return 1'b1;
      4'h1: return 1'b0;
      4'h2: return !(c | z);
      4'h3: return c | z;
      4'h4: return !c;
      4'h5: return c;
      4'h6: return !z;
      4'h7: return z;
      4'h8: return !v;
      4'h9: return v;
      4'ha: return !n;
      4'hb: return n;
      4'hc: return !(n ^ v);
      4'hd: return n ^ v;
      4'he: return !(z | (n ^ v));
      default: return z | (n ^ v);
    endcase
  endfunction : taken

  // operand 8'h5a with carry clear and 8'ha5 with carry set at every bit position
  task automatic bit_ops();
    logic [7:0] o, cc, st;
    logic c;
    for (int k = 0; k < 6; k++)
      for (int b = 0; b < 8; b++)
        for (int ci = 0; ci < 2; ci++) begin
          c = ci[0];
          o = c ? 8'ha5 : 8'h5a;
          cc = {7'h57, c};
          exec(bcb_pkg::bcb_op_t'(k), 4'h0, b[2:0], o, 24'h000040, 24'h000042, cc);
          st = o;
          st[b] = (k == 4) ? c : ~c;
          case (k)
            0: chk(g_ccr[0], {c ^ o[b]});
            1: chk(g_ccr[0], {c ^ ~o[b]});
            2: chk(g_ccr[0], {o[b]});
            3: chk(g_ccr[0], {~o[b]});
            4: chk(g_res, st);
            default: chk(g_res, st);
          endcase
          if (k < 4) begin
            chk(g_cwe, 1'b1);
            chk(g_ccr[7:1], cc[7:1]);
            chk(g_rwe, 1'b0);
          end else begin
            chk(g_rwe, 1'b1);
          end
        end
  endtask : bit_ops

  task automatic branches();
    logic [23:0] t;
    for (int cd = 0; cd < 16; cd++)
      for (int f = 0; f < 16; f++) begin
        t = 24'h001000 + 24'(cd * 16 + f);
        exec(bcb_pkg::cond_branch, cd[3:0], 3'h0, 8'h00, t, 24'h000080, {4'ha, f[3:0]});
        chk(g_pl, 1'b1);
        chk(g_pc, taken(cd[3:0], f[3:0]) ? t : 24'h000080);
      end
  endtask : branches

  task automatic calls();
    logic [31:0] d;
    logic [1:0] r;
    // never-taken code on a jump: it must be ignored
    exec(bcb_pkg::jump_absolute, 4'h1, 3'h0, 8'h00, 24'h00abc0, 24'h000010, 8'h00);
    chk(g_pc, 24'h00abc0);
    axi_wr(32'h8, 32'h1, r);
    chk(r, 2'h0);
    exec(bcb_pkg::call_relative, 4'h1, 3'h0, 8'h00, 24'h000200, 24'h000102, 8'h0f);
    chk(g_pc, 24'h000200);
    exec(bcb_pkg::call_absolute, 4'h1, 3'h0, 8'h00, 24'h003000, 24'h000204, 8'h00);
    chk(g_pc, 24'h003000);
    axi_rd(32'h0, d, r);
    chk(d & 32'h30f00, 32'h00200);
    exec(bcb_pkg::sub_return, 4'h0, 3'h0, 8'h00, 24'h0, 24'h000300, 8'h00);
    chk(g_pc, 24'h000204);
    chk(g_lat, 2);
    exec(bcb_pkg::sub_return, 4'h0, 3'h0, 8'h00, 24'h0, 24'h000302, 8'h00);
    chk(g_pc, 24'h000102);
    exec(bcb_pkg::sub_return, 4'h0, 3'h0, 8'h00, 24'h0, 24'h000777, 8'h00);
    chk(g_pc, 24'h000777);
    axi_rd(32'h0, d, r);
    chk(d & 32'h30f00, 32'h20000);
    axi_wr(32'h8, 32'h1, r);
    // nine calls: the ninth overflows and is not pushed
    for (int i = 0; i < 9; i++) begin
      exec(bcb_pkg::call_absolute, 4'h0, 3'h0, 8'h00, 24'h004000 + 24'(i), 24'h000500 + 24'(i), 8'h00);
    end
    axi_rd(32'h0, d, r);
    chk(d & 32'h30f00, 32'h10800);
    axi_rd(32'h4, d, r);
    chk(d, 32'h004008);
    exec(bcb_pkg::sub_return, 4'h0, 3'h0, 8'h00, 24'h0, 24'h000900, 8'h00);
    chk(g_pc, 24'h000507);
  endtask : calls

  task automatic reg_bus();
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(32'hc, d, r);
    chk(r, 2'h2);
    chk(d, 32'h0);
    axi_wr(32'hc, 32'hffffffff, r);
    chk(r, 2'h2);
    axi_wr(32'h4, 32'h00123456, r);
    chk(r, 2'h0);
    axi_rd(32'h4, d, r);
    chk(d, 32'h00000507);
    // depth 7 after the last pop, overflow still latched, flags of the last return
    axi_rd(32'h0, d, r);
    chk(d, 32'h00010700);
  endtask : reg_bus

  initial begin
    repeat (3) @(posedge clk_in);
    rstn_in <= 1'b1;
    chk(ready, 1'b1);
    chk(pc_o, 24'h0);
    chk({s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid}, 5'h1c);
    bit_ops();
    branches();
    calls();
    reg_bus();
    test_done();
  end
endmodule : bcb_exec_bench

`default_nettype wire
